// ### src/rlc_pkg.sv
// Package: register map, field layout, reset values and carrier types for the per-channel config bank
package rlc_pkg;

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam int unsigned NUM_CHAN = 4;
   localparam logic [7:0] CHAN_STRIDE = 8'h0c;
   localparam logic [7:0] RESISTANCE_MEASURE_CONFIG_OFFS = 8'h06;
   localparam logic [7:0] LEAKAGE_COMP_ENABLE_OFFS = 8'h07;
   localparam logic [7:0] DIGITAL_OUT_EXT_CONTROL_OFFS = 8'h08;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [15:0] RESISTANCE_MEASURE_CONFIG_RST = 16'h0001;
   localparam logic [15:0] LEAKAGE_COMP_ENABLE_RST = 16'h0000;
   localparam logic [15:0] DIGITAL_OUT_EXT_CONTROL_RST = 16'h1700;

   // ----------------------------------------------------------------
   // Writable bit masks; everything else is reserved and reads zero
   // ----------------------------------------------------------------
   localparam logic [15:0] RESISTANCE_MEASURE_CONFIG_WMASK = 16'h000f;
   localparam logic [15:0] LEAKAGE_COMP_ENABLE_WMASK = 16'h0001;
   localparam logic [15:0] DIGITAL_OUT_EXT_CONTROL_WMASK = 16'h1fff;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int unsigned REFERENCE_SCALE_SELECT_BIT = 3;
   localparam int unsigned WIRING_SELECT_BIT = 2;
   localparam int unsigned EXCITATION_SWAP_BIT = 1;
   localparam int unsigned EXCITATION_CURRENT_SELECT_BIT = 0;
   localparam int unsigned LEAKAGE_COMP_ON_BIT = 0;

   // ----------------------------------------------------------------
   // Carrier types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      RLC_SEL_RESISTANCE,
      RLC_SEL_LEAKAGE,
      RLC_SEL_DOEXT,
      RLC_SEL_NONE
   } rlc_sel_t;

   typedef struct packed {
      logic [15:0] resistance_measure_config;
      logic [15:0] leakage_comp_enable;
      logic [15:0] digital_out_ext_control;
   } rlc_chan_regs_t;

   typedef struct packed {
      logic ref_1v;
      logic two_wire;
      logic excitation_swap;
      logic current_1ma;
      logic leakage_comp_on;
   } rlc_chan_ctrl_t;

endpackage : rlc_pkg

// ### src/rlc_chan.sv
// Per-channel field decode and automatic ADC offset scaling
`timescale 1ns/1ps
module rlc_chan #(
   parameter int unsigned OFFSET_W = 24
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Register contents and channel status
   input wire rlc_pkg::rlc_chan_regs_t regs_i,
   input wire logic do_disabled_i,
   // Measurement request
   input wire logic meas_start_i,
   input wire logic [OFFSET_W-1:0] cal_offset_i,
   // Decoded controls and scaled offset
   output logic [$bits(rlc_pkg::rlc_chan_ctrl_t)-1:0] ctrl_o,
   output logic [OFFSET_W-1:0] scaled_offset_o,
   output logic offset_valid_o
);

   typedef struct packed {
      rlc_pkg::rlc_chan_ctrl_t ctrl;
      logic [OFFSET_W-1:0] offset;
      logic valid;
   } rlc_chan_state_t;

   rlc_chan_state_t state_reg;
   rlc_chan_state_t state_next;
   logic [15:0] rcfg;

   assign rcfg = regs_i.resistance_measure_config;

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      state_next = state_reg;
      state_next.ctrl.ref_1v = rcfg[rlc_pkg::REFERENCE_SCALE_SELECT_BIT];
      state_next.ctrl.two_wire = rcfg[rlc_pkg::WIRING_SELECT_BIT];
      // Swap is meaningless with two wires, so it is forced off there
      state_next.ctrl.excitation_swap = rcfg[rlc_pkg::EXCITATION_SWAP_BIT] &
         ~rcfg[rlc_pkg::WIRING_SELECT_BIT];
      state_next.ctrl.current_1ma = rcfg[rlc_pkg::EXCITATION_CURRENT_SELECT_BIT];
      state_next.ctrl.leakage_comp_on = regs_i.leakage_comp_enable[rlc_pkg::LEAKAGE_COMP_ON_BIT] &
         do_disabled_i;
      state_next.valid = 1'b0;
      if (meas_start_i) begin
         // Halving the reference doubles the offset in codes
         state_next.offset = rcfg[rlc_pkg::REFERENCE_SCALE_SELECT_BIT] ?
            {cal_offset_i[OFFSET_W-2:0], 1'b0} : cal_offset_i;
         state_next.valid = 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_reg <= '0;
         state_reg.ctrl.current_1ma <= 1'b1;
      end else begin
         state_reg <= state_next;
      end
   end

   assign ctrl_o = state_reg.ctrl;
   assign scaled_offset_o = state_reg.offset;
   assign offset_valid_o = state_reg.valid;

endmodule : rlc_chan

// ### src/rlc_bank.sv
// Register bank for resistance measurement, leakage compensation and digital output external control
//
// Summary of operation
// - Each register exists per channel at base plus twelve times channel number.
// - Resistance configuration resets to 0x0001, selecting the higher excitation current.
// - Bit 3 picks the reference: 0 means 2V, 1 means 1V.
// - Resistance measurements get the calibrated ADC offset scaled by selected reference.
// - Bit 2 picks wiring: 0 is three-wire, 1 is two-wire.
// - Bit 1 swaps excitation currents between sense pins, three-wire only.
// - Bit 0 picks excitation current: 0 is 500uA, 1 is 1mA; resets 1.
// - Leakage compensation acts only while digital output mode is disabled.
// - Leakage compensation bit 0 turns the circuit on or off; resets 0.
// - Digital output external control resets to 0x1700; bits 15 to 13 read-only.
`timescale 1ns/1ps
module rlc_bank #(
   parameter int unsigned NUM_CHAN = rlc_pkg::NUM_CHAN,
   parameter int unsigned OFFSET_W = 24
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Register access port behind the serial interface
   input wire logic [7:0] reg_addr_i,
   input wire logic reg_wr_en_i,
   input wire logic [15:0] reg_wr_data_i,
   input wire logic reg_rd_en_i,
   output logic [15:0] reg_rd_data_o,
   output logic reg_rd_hit_o,
   // Channel status and measurement requests
   input wire logic [NUM_CHAN-1:0] do_disabled_i,
   input wire logic [NUM_CHAN-1:0] meas_start_i,
   input wire logic [NUM_CHAN-1:0][OFFSET_W-1:0] cal_offset_i,
   // Decoded per-channel controls
   output rlc_pkg::rlc_chan_ctrl_t [NUM_CHAN-1:0] ctrl_o,
   output logic [NUM_CHAN-1:0][OFFSET_W-1:0] scaled_offset_o,
   output logic [NUM_CHAN-1:0] offset_valid_o,
   output logic [NUM_CHAN-1:0][12:0] do_ext_fields_o
);

   // ----------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------
   typedef struct packed {
      logic hit;
      logic [1:0] chan;
      rlc_pkg::rlc_sel_t sel;
   } rlc_dec_t;

   function automatic rlc_dec_t rlc_decode(input logic [7:0] addr);
      rlc_dec_t d;
      logic [7:0] base;
      d = '{hit: 1'b0, chan: 2'd0, sel: rlc_pkg::RLC_SEL_NONE};
      for (int i = 0; i < NUM_CHAN; i++) begin
         base = 8'(i * rlc_pkg::CHAN_STRIDE);
         if (addr == 8'(rlc_pkg::RESISTANCE_MEASURE_CONFIG_OFFS + base)) begin
            d = '{hit: 1'b1, chan: 2'(i), sel: rlc_pkg::RLC_SEL_RESISTANCE};
         end else if (addr == 8'(rlc_pkg::LEAKAGE_COMP_ENABLE_OFFS + base)) begin
            d = '{hit: 1'b1, chan: 2'(i), sel: rlc_pkg::RLC_SEL_LEAKAGE};
         end else if (addr == 8'(rlc_pkg::DIGITAL_OUT_EXT_CONTROL_OFFS + base)) begin
            d = '{hit: 1'b1, chan: 2'(i), sel: rlc_pkg::RLC_SEL_DOEXT};
         end
      end
      return d;
   endfunction : rlc_decode

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      rlc_pkg::rlc_chan_regs_t [NUM_CHAN-1:0] ch;
      logic [15:0] rd_data;
      logic rd_hit;
   } rlc_bank_state_t;

   rlc_bank_state_t state_reg;
   rlc_bank_state_t state_next;
   rlc_dec_t dec;

   assign dec = rlc_decode(reg_addr_i);

   always_comb begin
      state_next = state_reg;
      if (reg_wr_en_i && dec.hit) begin
         // Masking keeps reserved bits at zero whatever is written
         if (dec.sel == rlc_pkg::RLC_SEL_RESISTANCE) begin
            state_next.ch[dec.chan].resistance_measure_config =
               reg_wr_data_i & rlc_pkg::RESISTANCE_MEASURE_CONFIG_WMASK;
         end else if (dec.sel == rlc_pkg::RLC_SEL_LEAKAGE) begin
            state_next.ch[dec.chan].leakage_comp_enable =
               reg_wr_data_i & rlc_pkg::LEAKAGE_COMP_ENABLE_WMASK;
         end else if (dec.sel == rlc_pkg::RLC_SEL_DOEXT) begin
            state_next.ch[dec.chan].digital_out_ext_control =
               reg_wr_data_i & rlc_pkg::DIGITAL_OUT_EXT_CONTROL_WMASK;
         end
      end
      if (reg_rd_en_i) begin
         // Unmapped reads return zero with the hit flag low
         state_next.rd_hit = dec.hit;
         state_next.rd_data = 16'h0000;
         if (dec.hit && dec.sel == rlc_pkg::RLC_SEL_RESISTANCE) begin
            state_next.rd_data = state_reg.ch[dec.chan].resistance_measure_config;
         end else if (dec.hit && dec.sel == rlc_pkg::RLC_SEL_LEAKAGE) begin
            state_next.rd_data = state_reg.ch[dec.chan].leakage_comp_enable;
         end else if (dec.hit && dec.sel == rlc_pkg::RLC_SEL_DOEXT) begin
            state_next.rd_data = state_reg.ch[dec.chan].digital_out_ext_control;
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_reg.rd_data <= 16'h0000;
         state_reg.rd_hit <= 1'b0;
         for (int i = 0; i < NUM_CHAN; i++) begin
            state_reg.ch[i].resistance_measure_config <= rlc_pkg::RESISTANCE_MEASURE_CONFIG_RST;
            state_reg.ch[i].leakage_comp_enable <= rlc_pkg::LEAKAGE_COMP_ENABLE_RST;
            state_reg.ch[i].digital_out_ext_control <= rlc_pkg::DIGITAL_OUT_EXT_CONTROL_RST;
         end
      end else begin
         state_reg <= state_next;
      end
   end

   assign reg_rd_data_o = state_reg.rd_data;
   assign reg_rd_hit_o = state_reg.rd_hit;

   // ----------------------------------------------------------------
   // Per-channel decode
   // ----------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < NUM_CHAN; g++) begin : g_chan
         rlc_chan #(
            .OFFSET_W(OFFSET_W)
         ) u_chan (
            .clk_i(clk_i),
            .rst_n_i(rst_n_i),
            .regs_i(state_reg.ch[g]),
            .do_disabled_i(do_disabled_i[g]),
            .meas_start_i(meas_start_i[g]),
            .cal_offset_i(cal_offset_i[g]),
            .ctrl_o(ctrl_o[g]),
            .scaled_offset_o(scaled_offset_o[g]),
            .offset_valid_o(offset_valid_o[g])
         );
         assign do_ext_fields_o[g] = state_reg.ch[g].digital_out_ext_control[12:0];
      end
   endgenerate

endmodule : rlc_bank

// ### tb/rlc_bank_assertions.sv
// Checker: register port and decode assertions on the bank ports
`timescale 1ns/1ps
module rlc_bank_checker #(
   parameter int unsigned NUM_CHAN = 4,
   parameter int unsigned OFFSET_W = 24
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic reg_wr_en_i,
   input wire logic [15:0] reg_wr_data_i,
   input wire logic reg_rd_en_i,
   input wire logic [15:0] reg_rd_data_o,
   input wire logic reg_rd_hit_o,
   input wire logic [NUM_CHAN-1:0] do_disabled_i,
   input wire logic [NUM_CHAN-1:0] meas_start_i,
   input wire logic [NUM_CHAN-1:0][OFFSET_W-1:0] cal_offset_i,
   input wire rlc_pkg::rlc_chan_ctrl_t [NUM_CHAN-1:0] ctrl_o,
   input wire logic [NUM_CHAN-1:0][OFFSET_W-1:0] scaled_offset_o,
   input wire logic [NUM_CHAN-1:0] offset_valid_o,
   input wire logic [NUM_CHAN-1:0][12:0] do_ext_fields_o
);
   // ----------------------------------------------------------------
   // Register kind: 0 resistance, 1 leakage, 2 output control, 3 none
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   function automatic logic [1:0] kind(input logic [7:0] a);
      return (a < 8'h06 || a > 8'h2c || (a - 8'h06) % 8'h0c > 8'h02) ? 2'h3 : 2'((a - 8'h06) % 8'h0c);
   endfunction : kind
   chk_read_hit_map: assert property (reg_rd_en_i |=> reg_rd_hit_o == (kind($past(reg_addr_i)) != 2'h3))
      else $error("read hit flag wrong");
   chk_res_reserved: assert property (reg_rd_en_i && kind(reg_addr_i) == 2'h0 |=> reg_rd_data_o[15:4] == 12'h000)
      else $error("resistance reserved bits not zero");
   chk_leak_reserved: assert property (reg_rd_en_i && kind(reg_addr_i) == 2'h1 |=> reg_rd_data_o[15:1] == 15'h0)
      else $error("leakage reserved bits not zero");
   chk_doext_reserved: assert property (reg_rd_en_i && kind(reg_addr_i) == 2'h2 |=> reg_rd_data_o[15:13] == 3'h0)
      else $error("output control reserved bits not zero");
   chk_read_holds: assert property (!reg_rd_en_i |=> $stable(reg_rd_data_o))
      else $error("read data changed without a read");
   chk_valid_pulse: assert property (1'b1 |=> offset_valid_o == $past(meas_start_i))
      else $error("offset valid not one cycle after start");
   chk_offset_scale: assert property (meas_start_i[0] && !reg_wr_en_i && !$past(reg_wr_en_i) |=>
      scaled_offset_o[0] == ($past(ctrl_o[0].ref_1v) ? $past(cal_offset_i[0]) << 1 : $past(cal_offset_i[0])))
      else $error("scaled offset wrong");
   chk_swap_three_wire: assert property (ctrl_o[0].two_wire |-> !ctrl_o[0].excitation_swap)
      else $error("swap active in two-wire mode");
   chk_leak_gated: assert property (ctrl_o[0].leakage_comp_on |-> $past(do_disabled_i[0]))
      else $error("leakage compensation on while output enabled");
   chk_doext_write: assert property (reg_wr_en_i && reg_addr_i == 8'h08 |=>
      do_ext_fields_o[0] == $past(reg_wr_data_i[12:0]))
      else $error("output control fields not written");
   cover property (meas_start_i[0] && ctrl_o[0].ref_1v);
   cover property (reg_rd_en_i && kind(reg_addr_i) == 2'h3);
   cover property (ctrl_o[0].leakage_comp_on);
endmodule : rlc_bank_checker

// ### tb/rlc_host.sv
// Host model: register reads and writes on the port behind the serial interface
`timescale 1ns/1ps
module rlc_host (
   // Clock
   input wire logic clk_i,
   // Register port
   output logic [7:0] addr_o = 8'h00,
   output logic wr_en_o = 1'b0,
   output logic [15:0] wr_data_o = 16'h0000,
   output logic rd_en_o = 1'b0,
   input wire logic [15:0] rd_data_i,
   input wire logic rd_hit_i
);
   // Mux setting the host keeps in step with the wiring choice
   logic conversion_mux_select_to_agnd = 1'b0;
   task wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk_i);
      addr_o <= a;
      wr_data_o <= d;
      wr_en_o <= 1'b1;
      if ((a - 8'h06) % 8'h0c == 8'h00) conversion_mux_select_to_agnd = d[2];
      @(posedge clk_i);
      wr_en_o <= 1'b0;
      // Released lines carry the inverse so stale values cannot pass
      addr_o <= ~a;
      wr_data_o <= ~d;
   endtask : wr
   task rd(input logic [7:0] a, output logic [15:0] d, output logic h);
      @(posedge clk_i);
      addr_o <= a;
      rd_en_o <= 1'b1;
      @(posedge clk_i);
      rd_en_o <= 1'b0;
      addr_o <= ~a;
      #1;
      d = rd_data_i;
      h = rd_hit_i;
   endtask : rd
endmodule : rlc_host

// ### tb/rlc_bank_bench.sv
// Testbench: register map, field decode, leakage gating and offset scaling
`timescale 1ns/1ps
module rlc_bank_bench;
   logic clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic [7:0] addr;
   logic wr_en, rd_en, hit, h;
   logic [15:0] wr_data, rd_data, d;
   logic [3:0] do_dis = 4'h0;
   logic [3:0] start = 4'h0;
   logic [3:0][23:0] cal = '0;
   rlc_pkg::rlc_chan_ctrl_t [3:0] ctrl;
   logic [3:0][23:0] scaled;
   logic [3:0] valid;
   logic [3:0][12:0] doext;
   int error_cnt = 0;
   int total_checks = 0;
   localparam logic [15:0] RST_V [3] = '{16'h0001, 16'h0000, 16'h1700};
   localparam logic [15:0] MASK_V [3] = '{16'h000f, 16'h0001, 16'h1fff};
   localparam logic [7:0] BAD_A [4] = '{8'h05, 8'h09, 8'h11, 8'h2d};
   localparam logic [15:0] CFG_V [3] = '{16'h000a, 16'h0006, 16'h0001};
   localparam logic [4:0] CTRL_V [3] = '{5'h14, 5'h08, 5'h02};
   always #25 clk_i = ~clk_i;
   rlc_host u_host (.clk_i(clk_i), .addr_o(addr), .wr_en_o(wr_en), .wr_data_o(wr_data), .rd_en_o(rd_en),
      .rd_data_i(rd_data), .rd_hit_i(hit));
   rlc_bank u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .reg_addr_i(addr), .reg_wr_en_i(wr_en),
      .reg_wr_data_i(wr_data), .reg_rd_en_i(rd_en), .reg_rd_data_o(rd_data), .reg_rd_hit_o(hit),
      .do_disabled_i(do_dis), .meas_start_i(start), .cal_offset_i(cal), .ctrl_o(ctrl),
      .scaled_offset_o(scaled), .offset_valid_o(valid), .do_ext_fields_o(doext));
   task chk(input logic [23:0] got, input logic [23:0] exp);
      total_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task settle;
      repeat (2) @(posedge clk_i);
      #1;
   endtask : settle
   task meas(input logic [23:0] off);
      @(posedge clk_i);
      start <= 4'h1;
      cal[0] <= off;
      @(posedge clk_i);
      start <= 4'h0;
      #1;
   endtask : meas
   task report_and_stop;
      $display("Checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : report_and_stop
   // ----------------------------------------------------------------
   // Tests
   // ----------------------------------------------------------------
   initial begin
      repeat (3) @(posedge clk_i);
      rst_n_i <= 1'b1;
      for (int c = 0; c < 4; c++) begin
         for (int k = 0; k < 3; k++) begin
            u_host.rd(8'h06 + 8'(12 * c + k), d, h);
            chk(24'(d), 24'(RST_V[k]));
            chk(24'(h), 24'h1);
            u_host.wr(8'h06 + 8'(12 * c + k), 16'hffff);
            u_host.rd(8'h06 + 8'(12 * c + k), d, h);
            chk(24'(d), 24'(MASK_V[k]));
         end
      end
      chk(24'(doext[3]), 24'h1fff);
      foreach (BAD_A[i]) begin
         u_host.rd(BAD_A[i], d, h);
         chk(24'(h), 24'h0);
      end
      $display("Test map done");
      foreach (CFG_V[i]) begin
         u_host.wr(8'h06, CFG_V[i]);
         settle();
         chk(24'(ctrl[0]), 24'(CTRL_V[i]));
         chk(24'(u_host.conversion_mux_select_to_agnd), 24'(CFG_V[i][2]));
      end
      $display("Test decode done");
      @(posedge clk_i);
      do_dis <= 4'h1;
      settle();
      chk(24'(ctrl[0].leakage_comp_on), 24'h1);
      chk(24'(ctrl[1].leakage_comp_on), 24'h0);
      u_host.wr(8'h07, 16'h0000);
      settle();
      chk(24'(ctrl[0].leakage_comp_on), 24'h0);
      $display("Test leakage done");
      meas(24'h800010);
      chk(24'(valid[0]), 24'h1);
      chk(scaled[0], 24'h800010);
      u_host.wr(8'h06, 16'h0008);
      settle();
      meas(24'h800010);
      chk(scaled[0], 24'h000020);
      $display("Test offset done");
      report_and_stop();
   end
   initial begin
      repeat (2000) @(posedge clk_i);
      error_cnt++;
      report_and_stop();
   end
endmodule : rlc_bank_bench
bind rlc_bank rlc_bank_checker #(.NUM_CHAN(NUM_CHAN), .OFFSET_W(OFFSET_W)) u_chk (.clk_i(clk_i), .rst_n_i(rst_n_i),
   .reg_addr_i(reg_addr_i), .reg_wr_en_i(reg_wr_en_i), .reg_wr_data_i(reg_wr_data_i), .reg_rd_en_i(reg_rd_en_i),
   .reg_rd_data_o(reg_rd_data_o), .reg_rd_hit_o(reg_rd_hit_o), .do_disabled_i(do_disabled_i),
   .meas_start_i(meas_start_i), .cal_offset_i(cal_offset_i), .ctrl_o(ctrl_o), .scaled_offset_o(scaled_offset_o),
   .offset_valid_o(offset_valid_o), .do_ext_fields_o(do_ext_fields_o));
